// file: common/ccr_pkg.sv
`default_nettype none
package ccr_pkg;

  // ----------------------------------------------------------------
  // widths and map
  // ----------------------------------------------------------------
  localparam int          PC_W        = 12;
  localparam int          DATA_W      = 8;
  localparam int          PAGE_W      = 2;
  localparam int          STACK_DEPTH = 6;
  localparam int          STATIC_BIT  = 11;
  localparam int          SYNC_STAGES = 2;

  localparam logic [7:0]  ADDR_PTR1   = 8'h80;
  localparam logic [7:0]  ADDR_PTR2   = 8'h81;
  localparam logic [7:0]  ADDR_SD1    = 8'h82;
  localparam logic [7:0]  ADDR_SD2    = 8'h83;
  localparam logic [7:0]  ADDR_ACC    = 8'hff;

  // ----------------------------------------------------------------
  // reset values and vectors
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [11:0] PC_RESET    = 12'hffe;
  localparam logic [11:0] PC_NMI_VEC  = 12'hffc;
  localparam logic [1:0]  PAGE_STATIC = 2'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PC_HOLD,
    PC_NEXT,
    PC_JUMP,
    PC_CALL,
    PC_BRANCH,
    PC_IRQ,
    PC_RET,
    PC_SERVICE_EXIT_INSTRUCTION
  } ccr_pc_op_t;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_IRQ,
    MODE_NMI
  } ccr_mode_t;

  typedef struct packed {
    ccr_pc_op_t  op;
    logic [11:0] target;
    logic [7:0]  offset;
  } ccr_pc_cmd_t;

  typedef struct packed {
    logic carry;
    logic zero;
  } ccr_flags_t;

endpackage
`default_nettype wire

// file: logic/ccr_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_pin_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      level,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // ----------------------------------------------------------------
  // two-stage synchroniser, idle high
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign fall  = last_q & ~sync_q;

endmodule
`default_nettype wire

// file: logic/ccr_ret_stack.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_ret_stack #(
  parameter int DEPTH = ccr_pkg::STACK_DEPTH,
  parameter int WIDTH = ccr_pkg::PC_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_val,
  output logic      [WIDTH-1:0] top_val,
  output logic                  empty
);

  initial begin
    if (DEPTH < 2 || DEPTH > 15 || WIDTH < 1) $error("ccr_ret_stack: bad size");
  end

  logic [WIDTH-1:0] level_q [DEPTH];
  logic [3:0]       count_q;

  // ----------------------------------------------------------------
  // shift register levels; the deepest entry drops off on overflow
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_lvl
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        level_q[i] <= '0;
      end else if (push) begin
        level_q[i] <= (i == 0) ? push_val : level_q[(i == 0) ? 0 : i-1];
      end else if (pop && !empty) begin
        level_q[i] <= (i == DEPTH-1) ? '0 : level_q[(i == DEPTH-1) ? i : i+1];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_q <= 4'h0;
    end else if (push) begin
      if (count_q != 4'(DEPTH)) count_q <= count_q + 4'h1;
    end else if (pop && !empty) begin
      count_q <= count_q - 4'h1;
    end
  end

  assign top_val = level_q[0];
  assign empty   = (count_q == 4'h0);

endmodule
`default_nettype wire

// file: logic/ccr_core_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RULE_01 - six visible registers plus three carry/zero flag pairs
// RULE_02 - 8-bit accumulator read and written as data location ff
// RULE_03 - pointer registers at data locations 80 and 81, used indirectly
// RULE_04 - pointers also work as ordinary direct and bit-direct registers
// RULE_05 - short-direct registers at 82 and 83, direct and bit access
// RULE_06 - short-direct mode picks one of the two registers by one bit
// RULE_07 - 12-bit program counter addresses the next program byte
// RULE_08 - page select extends program reach past 4096 bytes
// RULE_09 - counter advances by one after each byte fetch
// RULE_10 - relative branch adds signed offset to the counter
// RULE_11 - jump/call load target, interrupt/reset vector, returns pop
// RULE_12 - low reset pin restarts at program start; idles high
// RULE_13 - nmi pin falling edge, asynchronous, highest priority
// RULE_14 - flag pair follows the mode; switching never clears flags
// RULE_15 - after reset the core runs in nmi mode
// RULE_16 - zero set on zero result, carry reflects carry or borrow
// RULE_17 - six-level 12-bit return stack; overflow loses deepest entry
// RULE_18 - written register value is seen by the very next instruction
module ccr_core_regs #(
  parameter int PAGE_W = ccr_pkg::PAGE_W
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     reset_pin_n,
  input  wire logic                     nmi_pin_n,
  input  wire logic [7:0]               ds_addr,
  input  wire logic [7:0]               ds_wdata,
  input  wire logic                     ds_we,
  input  wire logic                     ds_re,
  output logic      [7:0]               ds_rdata,
  output logic                          ds_hit,
  input  wire logic                     short_sel,
  output logic      [7:0]               short_addr,
  input  wire logic                     ind_sel,
  output logic      [7:0]               ind_addr,
  input  wire ccr_pkg::ccr_pc_cmd_t     pc_cmd,
  input  wire logic [11:0]              irq_vector,
  input  wire logic [PAGE_W-1:0]        program_page_select,
  output logic      [11:0]              program_counter,
  output logic      [PAGE_W+10:0]       rom_addr,
  input  wire logic                     alu_flag_we,
  input  wire logic [7:0]               alu_result,
  input  wire logic                     alu_carry,
  output ccr_pkg::ccr_flags_t           flags,
  output ccr_pkg::ccr_mode_t            mode,
  output logic                          nmi_req,
  output logic      [7:0]               accumulator,
  output logic                          core_rst
);

  initial begin
    if (PAGE_W < 1 || PAGE_W > 4) $error("ccr_core_regs: bad PAGE_W");
  end

  // ----------------------------------------------------------------
  // pin synchronisers and core reset
  // ----------------------------------------------------------------
  logic rpin_level;
  logic npin_fall;

  ccr_pin_sync u_rst_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (reset_pin_n),
    .level   (rpin_level),
    .fall    ()
  );

  ccr_pin_sync u_nmi_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (nmi_pin_n),
    .level   (),
    .fall    (npin_fall)
  );

  assign core_rst = rst | ~rpin_level; // RULE_12

  // ----------------------------------------------------------------
  // data-space registers
  // ----------------------------------------------------------------
  logic [7:0] pointer_one_q;
  logic [7:0] pointer_two_q;
  logic [7:0] short_direct_one_q;
  logic [7:0] short_direct_two_q;
  logic [7:0] accumulator_q;
  logic [7:0] rdata_q;
  logic       hit_q;
  logic       mapped;

  always_comb begin
    unique case (ds_addr)
      ccr_pkg::ADDR_PTR1, ccr_pkg::ADDR_PTR2,
      ccr_pkg::ADDR_SD1,  ccr_pkg::ADDR_SD2,
      ccr_pkg::ADDR_ACC: mapped = 1'b1;
      default:           mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      pointer_one_q      <= ccr_pkg::REG_RESET;
      pointer_two_q      <= ccr_pkg::REG_RESET;
      short_direct_one_q <= ccr_pkg::REG_RESET;
      short_direct_two_q <= ccr_pkg::REG_RESET;
      accumulator_q      <= ccr_pkg::REG_RESET;
    end else if (ds_we) begin
      if (ds_addr == ccr_pkg::ADDR_PTR1) pointer_one_q <= ds_wdata; // RULE_03
      if (ds_addr == ccr_pkg::ADDR_PTR2) pointer_two_q <= ds_wdata; // RULE_04
      if (ds_addr == ccr_pkg::ADDR_SD1) short_direct_one_q <= ds_wdata; // RULE_05
      if (ds_addr == ccr_pkg::ADDR_SD2) short_direct_two_q <= ds_wdata;
      if (ds_addr == ccr_pkg::ADDR_ACC) accumulator_q <= ds_wdata; // RULE_02
    end
  end

  // read data registered; unmapped answers zero with no hit
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      rdata_q <= 8'h00;
      hit_q   <= 1'b0;
    end else if (ds_re) begin
      hit_q <= mapped;
      unique case (ds_addr)
        ccr_pkg::ADDR_PTR1: rdata_q <= pointer_one_q;
        ccr_pkg::ADDR_PTR2: rdata_q <= pointer_two_q;
        ccr_pkg::ADDR_SD1:  rdata_q <= short_direct_one_q;
        ccr_pkg::ADDR_SD2:  rdata_q <= short_direct_two_q;
        ccr_pkg::ADDR_ACC:  rdata_q <= accumulator_q;
        default:            rdata_q <= 8'h00;
      endcase
    end else begin
      hit_q <= 1'b0;
    end
  end

  assign ds_rdata    = rdata_q;
  assign ds_hit      = hit_q;
  assign accumulator = accumulator_q; // RULE_18
  // one select bit replaces a full address byte
  assign short_addr  = short_sel ? ccr_pkg::ADDR_SD2 : ccr_pkg::ADDR_SD1; // RULE_06
  assign ind_addr    = ind_sel ? pointer_two_q : pointer_one_q; // RULE_03

  // ----------------------------------------------------------------
  // nmi latch and mode
  // ----------------------------------------------------------------
  ccr_pkg::ccr_mode_t mode_q;
  ccr_pkg::ccr_mode_t nmi_prev_q;
  logic               nmi_pend_q;
  logic               take_irq;
  logic               take_nmi;
  logic               take_service_exit_instruction;

  assign take_irq  = (pc_cmd.op == ccr_pkg::PC_IRQ);
  assign take_nmi  = take_irq && nmi_pend_q &&
                     (mode_q != ccr_pkg::MODE_NMI); // RULE_13
  assign take_service_exit_instruction = (pc_cmd.op == ccr_pkg::PC_SERVICE_EXIT_INSTRUCTION);

  // a new edge in the cycle of service keeps the request pending
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      nmi_pend_q <= 1'b0;
    end else if (npin_fall) begin
      nmi_pend_q <= 1'b1; // RULE_13
    end else if (take_nmi) begin
      nmi_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      mode_q     <= ccr_pkg::MODE_NMI; // RULE_15
      nmi_prev_q <= ccr_pkg::MODE_NORMAL;
    end else if (take_nmi) begin
      mode_q     <= ccr_pkg::MODE_NMI; // RULE_14
      nmi_prev_q <= mode_q;
    end else if (take_irq && mode_q == ccr_pkg::MODE_NORMAL) begin
      mode_q <= ccr_pkg::MODE_IRQ;
    end else if (take_service_exit_instruction) begin
      if (mode_q == ccr_pkg::MODE_NMI) mode_q <= nmi_prev_q; // RULE_14
      else mode_q <= ccr_pkg::MODE_NORMAL;
    end
  end

  assign mode    = mode_q;
  assign nmi_req = nmi_pend_q && (mode_q != ccr_pkg::MODE_NMI);

  // ----------------------------------------------------------------
  // flag pairs, one per mode
  // ----------------------------------------------------------------
  ccr_pkg::ccr_flags_t flag_q [3];

  for (genvar m = 0; m < 3; m++) begin : g_flag
    always_ff @(posedge clk_sys) begin
      if (core_rst) begin
        flag_q[m] <= '0;
      end else if (alu_flag_we && mode_q == ccr_pkg::ccr_mode_t'(m)) begin
        flag_q[m].carry <= alu_carry; // RULE_16
        flag_q[m].zero  <= (alu_result == 8'h00); // RULE_16
      end
    end
  end

  assign flags = flag_q[mode_q]; // RULE_01

  // ----------------------------------------------------------------
  // program counter and return stack
  // ----------------------------------------------------------------
  logic [11:0] pc_q;
  logic [11:0] alu_sum;
  logic [11:0] stack_top;
  logic        stack_empty;
  logic        do_push;
  logic        do_pop;

  // branch offset is sign-extended and added through the adder
  assign alu_sum = pc_q + {{4{pc_cmd.offset[7]}}, pc_cmd.offset}; // RULE_10
  assign do_push = (pc_cmd.op == ccr_pkg::PC_CALL) || take_irq;
  assign do_pop  = (pc_cmd.op == ccr_pkg::PC_RET) || take_service_exit_instruction;

  ccr_ret_stack u_stack (
    .clk_sys  (clk_sys),
    .rst      (core_rst),
    .push     (do_push),
    .pop      (do_pop),
    .push_val (pc_q),
    .top_val  (stack_top),
    .empty    (stack_empty)
  );

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      pc_q <= ccr_pkg::PC_RESET; // RULE_11
    end else begin
      unique case (pc_cmd.op)
        ccr_pkg::PC_HOLD:   pc_q <= pc_q;
        ccr_pkg::PC_NEXT:   pc_q <= pc_q + 12'h001; // RULE_09
        ccr_pkg::PC_JUMP,
        ccr_pkg::PC_CALL:   pc_q <= pc_cmd.target; // RULE_11
        ccr_pkg::PC_BRANCH: pc_q <= alu_sum; // RULE_10
        ccr_pkg::PC_IRQ:    pc_q <= take_nmi ? ccr_pkg::PC_NMI_VEC : irq_vector;
        ccr_pkg::PC_RET,
        ccr_pkg::PC_SERVICE_EXIT_INSTRUCTION:   pc_q <= stack_empty ? pc_q + 12'h001
                                                : stack_top; // RULE_17
      endcase
    end
  end

  assign program_counter = pc_q; // RULE_07
  // upper half is the static page, lower half is banked
  assign rom_addr = pc_q[ccr_pkg::STATIC_BIT]
                  ? {PAGE_W'(ccr_pkg::PAGE_STATIC), pc_q[10:0]}
                  : {program_page_select, pc_q[10:0]}; // RULE_08

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_pc_increment: assert property ( // RULE_09
    @(posedge clk_sys) disable iff (core_rst)
    pc_cmd.op == ccr_pkg::PC_NEXT |=> pc_q == $past(pc_q) + 12'h001)
    else $error("pc did not advance by one");

  chk_pc_jump_load: assert property ( // RULE_11
    @(posedge clk_sys) disable iff (core_rst)
    pc_cmd.op inside {ccr_pkg::PC_JUMP, ccr_pkg::PC_CALL}
    |=> pc_q == $past(pc_cmd.target))
    else $error("jump target not loaded");

  chk_branch_sum: assert property ( // RULE_10
    @(posedge clk_sys) disable iff (core_rst)
    pc_cmd.op == ccr_pkg::PC_BRANCH
    |=> pc_q == $past(pc_q) + {{4{$past(pc_cmd.offset[7])}},
                               $past(pc_cmd.offset)})
    else $error("branch sum wrong");

  chk_call_return: assert property ( // RULE_17
    @(posedge clk_sys) disable iff (core_rst)
    (pc_cmd.op == ccr_pkg::PC_CALL) ##1 (pc_cmd.op == ccr_pkg::PC_RET)
    |=> pc_q == $past(pc_q, 2))
    else $error("return address lost");

  chk_nmi_priority: assert property ( // RULE_13
    @(posedge clk_sys) disable iff (core_rst)
    take_irq && nmi_pend_q && mode_q != ccr_pkg::MODE_NMI
    |=> pc_q == ccr_pkg::PC_NMI_VEC && mode_q == ccr_pkg::MODE_NMI)
    else $error("nmi not preferred");

  chk_nmi_edge: assert property ( // RULE_13
    @(posedge clk_sys) disable iff (core_rst)
    npin_fall |=> nmi_pend_q)
    else $error("nmi edge dropped");

  chk_reset_mode: assert property ( // RULE_15
    @(posedge clk_sys)
    core_rst |=> mode_q == ccr_pkg::MODE_NMI && pc_q == ccr_pkg::PC_RESET)
    else $error("reset mode not nmi");

  chk_flag_keep: assert property ( // RULE_14
    @(posedge clk_sys) disable iff (core_rst)
    (mode_q != $past(mode_q)) && !$past(alu_flag_we)
    |-> flag_q[0] == $past(flag_q[0]) && flag_q[1] == $past(flag_q[1])
        && flag_q[2] == $past(flag_q[2]))
    else $error("flags changed on mode switch");

  chk_zero_flag: assert property ( // RULE_16
    @(posedge clk_sys) disable iff (core_rst)
    alu_flag_we ##1 (mode_q == $past(mode_q))
    |-> flags.zero == ($past(alu_result) == 8'h00)
        && flags.carry == $past(alu_carry))
    else $error("flag value wrong");

  chk_acc_write: assert property ( // RULE_18
    @(posedge clk_sys) disable iff (core_rst)
    ds_we && ds_addr == ccr_pkg::ADDR_ACC
    ##1 ds_re && ds_addr == ccr_pkg::ADDR_ACC && !ds_we
    |=> ds_rdata == $past(ds_wdata, 2) && ds_hit)
    else $error("accumulator write not seen");

endmodule
`default_nettype wire

// file: bench/ccr_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_pin_model (
  input  wire logic hold_reset,
  input  wire logic hold_nmi,
  output logic      reset_pin_n,
  output logic      nmi_pin_n
);
  // --------------------------------------------------------------
  // pins idle high while hold_reset and hold_nmi are low
  // --------------------------------------------------------------
  assign reset_pin_n = ~hold_reset;
  assign nmi_pin_n   = ~hold_nmi;
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic                 clk_sys;
  logic                 rst;
  logic                 hold_reset;
  logic                 hold_nmi;
  logic                 reset_pin_n;
  logic                 nmi_pin_n;
  logic [7:0]           ds_addr;
  logic [7:0]           ds_wdata;
  logic                 ds_we;
  logic                 ds_re;
  logic [7:0]           ds_rdata;
  logic                 ds_hit;
  logic                 short_sel;
  logic [7:0]           short_addr;
  logic                 ind_sel;
  logic [7:0]           ind_addr;
  ccr_pkg::ccr_pc_cmd_t pc_cmd;
  logic [11:0]          irq_vector;
  logic [1:0]           program_page_select;
  logic [11:0]          program_counter;
  logic [12:0]          rom_addr;
  logic                 alu_flag_we;
  logic [7:0]           alu_result;
  logic                 alu_carry;
  ccr_pkg::ccr_flags_t  flags;
  ccr_pkg::ccr_mode_t   mode;
  logic                 nmi_req;
  logic [7:0]           accumulator;
  logic                 core_rst;
  int                   n_fail;
  int                   check_count;

  localparam ccr_pkg::ccr_pc_cmd_t HOLDC = '{ccr_pkg::PC_HOLD, 12'h000,
                                             8'h00};

  ccr_pin_model i_ccr_pin_model (
    .hold_reset (hold_reset),
    .hold_nmi   (hold_nmi),
    .reset_pin_n(reset_pin_n),
    .nmi_pin_n  (nmi_pin_n)
  );

  ccr_core_regs i_ccr_core_regs (
    .clk_sys(clk_sys), .rst(rst), .reset_pin_n(reset_pin_n),
    .nmi_pin_n(nmi_pin_n), .ds_addr(ds_addr), .ds_wdata(ds_wdata),
    .ds_we(ds_we), .ds_re(ds_re), .ds_rdata(ds_rdata), .ds_hit(ds_hit),
    .short_sel(short_sel), .short_addr(short_addr), .ind_sel(ind_sel),
    .ind_addr(ind_addr), .pc_cmd(pc_cmd), .irq_vector(irq_vector),
    .program_page_select(program_page_select),
    .program_counter(program_counter), .rom_addr(rom_addr),
    .alu_flag_we(alu_flag_we), .alu_result(alu_result),
    .alu_carry(alu_carry), .flags(flags), .mode(mode),
    .nmi_req(nmi_req), .accumulator(accumulator), .core_rst(core_rst)
  );

  // --------------------------------------------------------------
  // drivers and compare
  // --------------------------------------------------------------
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick;
    @(posedge clk_sys);
    #10;
  endtask

  // every strobe is set once per cycle, so nothing is assigned twice
  task automatic go(logic we, logic re, logic fw,
                    ccr_pkg::ccr_pc_cmd_t c);
    ds_we = we;
    ds_re = re;
    alu_flag_we = fw;
    pc_cmd = c;
    tick();
  endtask

  task automatic op(ccr_pkg::ccr_pc_op_t o, logic [11:0] t, logic [7:0] f);
    go(1'b0, 1'b0, 1'b0, '{o, t, f});
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    ds_addr = a;
    ds_wdata = d;
    go(1'b1, 1'b0, 1'b0, HOLDC);
  endtask

  task automatic rd(logic [7:0] a);
    ds_addr = a;
    go(1'b0, 1'b1, 1'b0, HOLDC);
  endtask

  task automatic alu(logic [7:0] r, logic c);
    alu_result = r;
    alu_carry = c;
    go(1'b0, 1'b0, 1'b1, HOLDC);
  endtask

  task automatic quiet;
    go(1'b0, 1'b0, 1'b0, HOLDC);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] a [5] = '{ccr_pkg::ADDR_PTR1, ccr_pkg::ADDR_PTR2,
      ccr_pkg::ADDR_SD1, ccr_pkg::ADDR_SD2, ccr_pkg::ADDR_ACC};
    for (int i = 0; i < 5; i++) begin
      rd(a[i]);
      chk("reset value", 16'(ccr_pkg::REG_RESET), 16'(ds_rdata));
      wr(a[i], 8'(8'h5a + i * 17));
      rd(a[i]);
      chk("read back", 16'(8'(8'h5a + i * 17)), 16'(ds_rdata));
      chk("hit", 16'h1, 16'(ds_hit));
    end
    chk("accumulator", 16'h9e, 16'(accumulator));
    ind_sel = 1'b0;
    short_sel = 1'b0;
    quiet();
    chk("ind addr 0", 16'h5a, 16'(ind_addr));
    chk("short addr 0", 16'(ccr_pkg::ADDR_SD1), 16'(short_addr));
    ind_sel = 1'b1;
    short_sel = 1'b1;
    quiet();
    chk("ind addr 1", 16'h6b, 16'(ind_addr));
    chk("short addr 1", 16'(ccr_pkg::ADDR_SD2), 16'(short_addr));
    wr(8'h84, 8'h77);
    rd(8'h84);
    chk("unmapped data", 16'h0, 16'(ds_rdata));
    chk("unmapped hit", 16'h0, 16'(ds_hit));
    chk("unmapped write", 16'h9e, 16'(accumulator));
    quiet();
  endtask

  task automatic t_pc;
    chk("reset mode", 16'(ccr_pkg::MODE_NMI), 16'(mode));
    chk("reset pc", 16'(ccr_pkg::PC_RESET), 16'(program_counter));
    op(ccr_pkg::PC_NEXT, 12'h000, 8'h00);
    chk("pc next", 16'hfff, 16'(program_counter));
    op(ccr_pkg::PC_NEXT, 12'h000, 8'h00);
    chk("pc wrap", 16'h000, 16'(program_counter));
    op(ccr_pkg::PC_JUMP, 12'h010, 8'h00);
    chk("pc jump", 16'h010, 16'(program_counter));
    op(ccr_pkg::PC_BRANCH, 12'h000, 8'hf0);
    chk("branch back", 16'h000, 16'(program_counter));
    op(ccr_pkg::PC_BRANCH, 12'h000, 8'h7f);
    chk("branch fwd", 16'h07f, 16'(program_counter));
    program_page_select = 2'h2;
    op(ccr_pkg::PC_JUMP, 12'h123, 8'h00);
    chk("paged addr", 16'({2'h2, 11'h123}), 16'(rom_addr));
    op(ccr_pkg::PC_JUMP, 12'h923, 8'h00);
    chk("static addr", 16'({ccr_pkg::PAGE_STATIC, 11'h123}),
        16'(rom_addr));
  endtask

  task automatic t_stack;
    op(ccr_pkg::PC_JUMP, 12'h100, 8'h00);
    for (int i = 0; i < 7; i++)
      op(ccr_pkg::PC_CALL, 12'(12'h200 + i), 8'h00);
    for (int i = 0; i < 6; i++) begin
      op(ccr_pkg::PC_RET, 12'h000, 8'h00);
      chk("pop", 16'(12'h205 - i), 16'(program_counter));
    end
    op(ccr_pkg::PC_RET, 12'h000, 8'h00);
    chk("empty pop", 16'h201, 16'(program_counter));
  endtask

  task automatic t_flags;
    logic [11:0] p;
    alu(8'h00, 1'b1);
    chk("nmi pair", 16'h3, 16'(flags));
    op(ccr_pkg::PC_SERVICE_EXIT_INSTRUCTION, 12'h000, 8'h00);
    chk("mode after exit", 16'(ccr_pkg::MODE_NORMAL), 16'(mode));
    chk("normal pair", 16'h0, 16'(flags));
    alu(8'h05, 1'b1);
    chk("normal write", 16'h2, 16'(flags));
    p = program_counter;
    irq_vector = 12'h3a0;
    op(ccr_pkg::PC_IRQ, 12'h000, 8'h00);
    chk("irq vector", 16'h3a0, 16'(program_counter));
    chk("irq mode", 16'(ccr_pkg::MODE_IRQ), 16'(mode));
    chk("irq pair", 16'h0, 16'(flags));
    alu(8'h00, 1'b0);
    chk("irq write", 16'h1, 16'(flags));
    op(ccr_pkg::PC_SERVICE_EXIT_INSTRUCTION, 12'h000, 8'h00);
    chk("irq return", 16'(p), 16'(program_counter));
    chk("kept pair", 16'h2, 16'(flags));
    quiet();
  endtask

  task automatic t_nmi;
    logic [11:0] p;
    int          n;
    n = 0;
    hold_nmi = 1'b1;
    while (nmi_req !== 1'b1 && n < 6) begin
      tick();
      n++;
    end
    chk("nmi latency", 16'h3, 16'(n));
    hold_nmi = 1'b0;
    p = program_counter;
    op(ccr_pkg::PC_IRQ, 12'h000, 8'h00);
    chk("nmi wins", 16'(ccr_pkg::PC_NMI_VEC), 16'(program_counter));
    chk("nmi mode", 16'(ccr_pkg::MODE_NMI), 16'(mode));
    chk("nmi served", 16'h0, 16'(nmi_req));
    op(ccr_pkg::PC_SERVICE_EXIT_INSTRUCTION, 12'h000, 8'h00);
    chk("nmi return", 16'(p), 16'(program_counter));
    quiet();
  endtask

  task automatic t_rstpin;
    op(ccr_pkg::PC_JUMP, 12'h456, 8'h00);
    quiet();
    hold_reset = 1'b1;
    repeat (3) tick();
    chk("pin reset", 16'h1, 16'(core_rst));
    hold_reset = 1'b0;
    repeat (3) tick();
    chk("pin release", 16'h0, 16'(core_rst));
    chk("restart pc", 16'(ccr_pkg::PC_RESET), 16'(program_counter));
    chk("restart mode", 16'(ccr_pkg::MODE_NMI), 16'(mode));
    chk("acc cleared", 16'(ccr_pkg::REG_RESET), 16'(accumulator));
  endtask

  // --------------------------------------------------------------
  // clock, sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    n_fail = 0;
    check_count = 0;
    rst = 1'b1;
    hold_reset = 1'b0;
    hold_nmi = 1'b0;
    ds_addr = 8'h00;
    ds_wdata = 8'h00;
    ds_we = 1'b0;
    ds_re = 1'b0;
    short_sel = 1'b0;
    ind_sel = 1'b0;
    pc_cmd = HOLDC;
    irq_vector = 12'h000;
    program_page_select = 2'h0;
    alu_flag_we = 1'b0;
    alu_result = 8'h00;
    alu_carry = 1'b0;
    repeat (6) @(posedge clk_sys);
    #10 rst = 1'b0;
    tick();
    t_pc();
    t_regs();
    t_stack();
    t_flags();
    t_nmi();
    t_rstpin();
    wrap_up();
  end

  initial begin
    repeat (2000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
